// >>> dv/boot_entry_and_flash_self_program_tb.sv
// Purpose: scenario bench for boot entry and flash self-programming
// Assumes: APB master on ref_clk, flash model answers operations
// Notes: a command is pointer, control and store writes in a row
`timescale 1ns/1ps
`default_nettype none
`include "self_program_cfg.svh"

module boot_entry_and_flash_self_program_tb;
  localparam logic [15:0] LOADER = 16'h1000; // loader reset address
  localparam logic [15:0] PG3 = 16'h0180; // page 3, readable section
  localparam logic [15:0] PGH = 16'h7000; // page 224, halting section
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, er, slow, eeprom_write;
  logic rst_fuse, hwb_fuse, boot_pin, done, erase_go, write_go, entry, blocked, halt, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] buf_index;
  logic [15:0] buf_word, rd_word, vector;
  logic [8:0] page;
  logic [14:0] rd_addr;
  logic [3:0] locks;
  int errors, comparisons;

  self_program_ctrl #(.BOOT_VECTOR(LOADER)) self_program_ctrl_i (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_reset_select_fuse(rst_fuse), .hardware_boot_enable_fuse(hwb_fuse),
    .hardware_boot_pin(boot_pin), .eeprom_write(eeprom_write), .flash_done(done),
    .flash_buf_index(buf_index), .flash_buf_word(buf_word), .flash_erase_start(erase_go),
    .flash_write_start(write_go), .flash_page(page), .flash_rd_addr(rd_addr),
    .flash_rd_word(rd_word), .reset_vector(vector), .boot_entry(entry), .core_halt(halt),
    .readable_section_blocked(blocked), .self_program_irq(irq), .boot_lock_bits(locks));
  flash_macro_model flash_macro_model_i (
    .ref_clk(ref_clk), .reset(reset), .slow(slow), .start(erase_go | write_go),
    .buf_word(buf_word), .rd_addr(rd_addr), .buf_index(buf_index), .rd_word(rd_word),
    .done(done));

  // free-running system clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // x never matches thanks to case inequality
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one transfer plus one idle edge, so psel is never set twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("unexpected at %0t: bus answer timed out", $time);
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  // command with interrupt enable kept on, then let the start land
  task automatic go(input logic [7:0] p, input logic [15:0] ptr);
    apb(1'b1, `OFS_POINTER, {16'h0, ptr});
    apb(1'b1, `OFS_CONTROL, {24'h0, 8'h80 | p});
    apb(1'b1, `OFS_STORE, 32'h0);
    @(posedge ref_clk);
  endtask : go
  // one buffer word, each index used once per fill
  task automatic lw(input logic [5:0] ix, input logic [15:0] d);
    apb(1'b1, `OFS_DATA, {16'h0, d});
    go(8'h01, PG3 | {9'h0, ix, 1'b0});
  endtask : lw
  // poll the enable bit, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `OFS_CONTROL, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    if (n >= 200) begin
      errors++;
      $display("unexpected at %0t: enable bit never cleared", $time);
      complete_run();
    end
  endtask : wait_idle

  task automatic t_boot();
    logic e;
    for (int i = 0; i < 8; i++) begin
      rst_fuse <= i[2];
      hwb_fuse <= i[1];
      boot_pin <= i[0];
      reset <= 1'b1;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      e = ~i[2] | (~i[1] & ~i[0]);
      apb(1'b0, `OFS_BOOT, 32'h0);
      chk(rd, {15'h0, e, e ? LOADER : 16'h0000});
      chk(vector, e ? LOADER : 16'h0000);
    end
    apb(1'b1, `OFS_BOOT, 32'h0001_1000);
    apb(1'b0, `OFS_BOOT, 32'h0);
    chk(rd, 32'h0000_0000);
    $display("boot vector test ended");
  endtask : t_boot

  task automatic t_write();
    lw(6'd63, 16'h1111);
    lw(6'd5, 16'h2222);
    lw(6'd0, 16'h3333);
    go(8'h05, PG3);
    chk(blocked, 1'b1);
    chk(halt, 1'b0);
    chk(irq, 1'b0);
    apb(1'b1, `OFS_POINTER, 32'h0000_0003);
    chk(page, 9'd3);
    apb(1'b0, `OFS_PM_LOAD, 32'h0);
    chk(er, 1'b1);
    wait_idle();
    chk(irq, 1'b1);
    chk(blocked, 1'b1);
    chk(flash_macro_model_i.captured[63], 16'h1111);
    chk(flash_macro_model_i.captured[5], 16'h2222);
    chk(flash_macro_model_i.captured[0], 16'h3333);
    chk(flash_macro_model_i.captured[1], 16'hffff);
    go(8'h05, PG3);
    wait_idle();
    chk(flash_macro_model_i.captured[5], 16'hffff);
    lw(6'd5, 16'h4444);
    eeprom_write <= 1'b1;
    @(posedge ref_clk);
    eeprom_write <= 1'b0;
    go(8'h05, PG3);
    wait_idle();
    chk(flash_macro_model_i.captured[5], 16'hffff);
    go(8'h11, 16'h0003);
    chk(blocked, 1'b0);
    apb(1'b0, `OFS_PM_LOAD, 32'h0);
    chk(rd, 32'h0000_00da);
    apb(1'b1, `OFS_POINTER, 32'h0000_0002);
    apb(1'b0, `OFS_PM_LOAD, 32'h0);
    chk(rd, 32'h0000_005b);
    $display("page write test ended");
  endtask : t_write

  task automatic t_halt();
    slow <= 1'b1;
    lw(6'd2, 16'h5555);
    go(8'h03, PGH);
    chk(halt, 1'b1);
    chk(irq, 1'b0);
    wait_idle();
    chk(halt, 1'b0);
    go(8'h05, PGH);
    chk(halt, 1'b1);
    wait_idle();
    chk(flash_macro_model_i.captured[2], 16'h5555);
    slow <= 1'b0;
    $display("halting section test ended");
  endtask : t_halt

  task automatic t_lock();
    go(8'h11, 16'h0);
    apb(1'b1, `OFS_DATA, 32'h0000_ffd7);
    go(8'h09, 16'h0001);
    chk(blocked, 1'b0);
    chk(halt, 1'b0);
    apb(1'b0, `OFS_LOCK, 32'h0);
    chk(rd, 32'h0000_0005);
    chk(locks, 32'h0000_0005);
    apb(1'b1, `OFS_DATA, 32'h0000_00ff);
    go(8'h09, 16'h0001);
    apb(1'b0, `OFS_LOCK, 32'h0);
    chk(rd, 32'h0000_0005);
    $display("lock test ended");
  endtask : t_lock

  task automatic t_misc();
    apb(1'b1, `OFS_CONTROL, 32'h0000_0081);
    repeat (5) @(posedge ref_clk);
    apb(1'b0, `OFS_CONTROL, 32'h0);
    chk(rd, 32'h0000_0080);
    go(8'h07, PG3);
    chk(blocked, 1'b0);
    apb(1'b0, `OFS_CONTROL, 32'h0);
    chk(rd, 32'h0000_0080);
    apb(1'b0, `OFS_LOCK, 32'h0);
    chk(rd, 32'h0000_0005);
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1);
    $display("expiry and no-op test ended");
  endtask : t_misc

  // main sequence
  initial begin
    errors = 0;
    comparisons = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst_fuse = 1'b1;
    hwb_fuse = 1'b1;
    boot_pin = 1'b1;
    eeprom_write = 1'b0;
    slow = 1'b0;
    t_boot();
    t_write();
    t_halt();
    t_lock();
    t_misc();
    complete_run();
  end
endmodule : boot_entry_and_flash_self_program_tb
`default_nettype wire

// >>> dv/flash_macro_model.sv
// Purpose: flash array stand-in that runs erase and write operations
// Assumes: start pulses last one cycle, buffer word lags index by one
// Notes: slow stretches an operation to show long busy periods
`timescale 1ns/1ps
`default_nettype none

module flash_macro_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic start,
  input wire logic [15:0] buf_word,
  input wire logic [14:0] rd_addr,
  output logic [5:0] buf_index,
  output logic [15:0] rd_word,
  output logic done
);
  logic [15:0] captured [0:63]; // page image taken from the buffer
  logic [8:0] cnt; // cycles into the operation
  logic busy; // operation running
  assign buf_index = cnt[5:0];
  // word differs per address so byte selection is visible
  assign rd_word = {1'b1, rd_addr} ^ 16'h5a5a;
  // walk the buffer, then report completion after a fixed time
  always_ff @(posedge ref_clk) begin
    done <= 1'b0;
    if (reset) begin
      busy <= 1'b0;
      cnt <= 9'd0;
    end else if (start) begin
      busy <= 1'b1;
      cnt <= 9'd0;
    end else if (busy) begin
      cnt <= cnt + 9'd1;
      if (cnt >= 9'd1 && cnt <= 9'd64) begin
        captured[cnt[5:0] - 6'd1] <= buf_word;
      end
      if (cnt == (slow ? 9'd300 : 9'd70)) begin
        done <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule : flash_macro_model
`default_nettype wire

// >>> dv/self_program_ctrl_checker.sv
// Purpose: port-level checks on the self-programming controller
// Assumes: one ref_clk domain, fuses change only while reset is held
// Notes: bound to self_program_ctrl below
`timescale 1ns/1ps
`default_nettype none
`include "self_program_cfg.svh"

module self_program_ctrl_checker #(
  parameter logic [15:0] BOOT_VECTOR = 16'h1000,
  parameter int HALT_START_PAGE = 224
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [7:0] paddr,
  input wire logic boot_reset_select_fuse,
  input wire logic hardware_boot_enable_fuse,
  input wire logic flash_done,
  input wire logic flash_erase_start,
  input wire logic flash_write_start,
  input wire logic [8:0] flash_page,
  input wire logic [15:0] reset_vector,
  input wire logic boot_entry,
  input wire logic core_halt,
  input wire logic readable_section_blocked,
  input wire logic self_program_irq,
  input wire logic [3:0] boot_lock_bits
);
  logic st1; // store seen one edge ago
  logic st2; // store seen two edges ago
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // two-deep history of store writes, flag update may lag one cycle
  always_ff @(posedge ref_clk) begin
    st1 <= !reset && psel && penable && pready && pwrite && paddr == `OFS_STORE;
    st2 <= !reset && st1;
  end
  // erase or write launched
  sequence op_start_s;
    flash_erase_start || flash_write_start;
  endsequence
  // a recent store is the only thing that may move flags
  sequence store_s;
    st1 || st2;
  endsequence
  op_blocks_a: assert property (op_start_s |-> readable_section_blocked)
    else $error("operation started with section readable");
  busy_clear_a: assert property ($fell(readable_section_blocked) |-> store_s)
    else $error("busy flag fell without a store");
  lock_store_a: assert property ($changed(boot_lock_bits) |-> store_s)
    else $error("lock bits moved without a store");
  halt_on_a: assert property (op_start_s |=> core_halt == (flash_page >= HALT_START_PAGE))
    else $error("halt does not match target section");
  halt_hold_a: assert property (core_halt && !flash_done |=> core_halt)
    else $error("halt dropped before completion");
  halt_end_a: assert property (core_halt && flash_done |=> !core_halt)
    else $error("halt held after completion");
  irq_quiet_a: assert property (core_halt |-> !self_program_irq)
    else $error("interrupt raised while operation runs");
  vector_match_a: assert property (reset_vector == (boot_entry ? BOOT_VECTOR : 16'h0000))
    else $error("reset vector disagrees with boot entry");
  entry_fuse_a: assert property (boot_entry |-> !boot_reset_select_fuse || !hardware_boot_enable_fuse)
    else $error("loader entered with both fuses unprogrammed");
  loader_fuse_a: assert property (!boot_reset_select_fuse && !$past(reset) |-> boot_entry)
    else $error("programmed boot fuse did not select loader");
endmodule : self_program_ctrl_checker

bind self_program_ctrl self_program_ctrl_checker #(
  .BOOT_VECTOR(BOOT_VECTOR),
  .HALT_START_PAGE(HALT_START_PAGE)
) self_program_ctrl_checker_i (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .paddr(paddr), .boot_reset_select_fuse(boot_reset_select_fuse),
  .hardware_boot_enable_fuse(hardware_boot_enable_fuse), .flash_done(flash_done),
  .flash_erase_start(flash_erase_start), .flash_write_start(flash_write_start),
  .flash_page(flash_page), .reset_vector(reset_vector), .boot_entry(boot_entry),
  .core_halt(core_halt), .readable_section_blocked(readable_section_blocked),
  .self_program_irq(self_program_irq), .boot_lock_bits(boot_lock_bits)
);
`default_nettype wire

// >>> inc/self_program_cfg.svh
// Purpose: constants for boot entry and flash self-programming control
// Assumes: one 100 MHz clock, APB slave with one 32-bit word per register
// Notes: offsets are byte addresses; field positions count from bit 0
//
// Summary of operation
// - boot reset fuse picks application or loader
// - core can never change any fuse
// - boot enable fuse lets pin force loader
// - pin sampled on reset release; low selects loader
// - pointer gives page and word; page latched at start
// - pointer bit zero picks byte on loads
// - erase pattern plus store within four cycles
// - load pattern stores data word at word index
// - buffer cleared after write, reenable, reset
// - eeprom write during loading discards buffer
// - write pattern plus store starts page write
// - halting section target stalls core until done
// - interrupt held while enable bit reads clear and interrupt enable set
// - erase or write blocks readable section, busy
// - lock pattern plus store programs boot locks
// - zero data bits five..two program lock bits
// - lock programming never blocks or halts
// - no store in four cycles clears enables
// - busy flag reads one while reads blocked
`ifndef SELF_PROGRAM_CFG_SVH
`define SELF_PROGRAM_CFG_SVH

// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_POINTER 8'h04
`define OFS_DATA 8'h08
`define OFS_STORE 8'h0C
`define OFS_LOCK 8'h10
`define OFS_PM_LOAD 8'h14
`define OFS_BOOT 8'h18

// control register field positions
`define BIT_SELF_PROGRAM_ENABLE_BIT 0
`define BIT_PGERS 1
`define BIT_PGWRT 2
`define BIT_LOCK_SET_ENABLE_BIT 3
`define BIT_REEN 4
`define BIT_SIGRD 5
`define BIT_BUSY 6
`define BIT_IRQEN 7

// command patterns on control bits 5..0 (bit 7 is a don't care)
`define PAT_LOAD 6'h01
`define PAT_ERASE 6'h03
`define PAT_WRITE 6'h05
`define PAT_LOCK 6'h09
`define PAT_REEN 6'h11

// lock field inside the low data register
`define LOCK_LSB 2
`define LOCK_MSB 5

// reset values
`define RST_LOCK 4'hF
`define RST_APP_VECTOR 16'h0000

// store must follow the control write within this many cycles
`define STORE_WINDOW_CYCLES 3'h4

`endif

// >>> inc/self_program_pkg.sv
// Purpose: shared types for the self-programming controller
// Assumes: constants live in self_program_cfg.svh
// Notes: types only, no numbers
package self_program_pkg;

  // decoded command at the moment of a store
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_LOAD,
    CMD_ERASE,
    CMD_WRITE,
    CMD_LOCK,
    CMD_REEN
  } cmd_t;

  // long flash operation in progress
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_ERASE,
    OP_WRITE
  } op_state_t;

endpackage : self_program_pkg

// >>> src/page_buffer.sv
// Purpose: temporary page buffer, one word per location, in flip-flops
// Assumes: load and clear are one-cycle strobes on ref_clk
// Notes: clear wins over load; read port is registered
`timescale 1ns/1ps
`default_nettype none

module page_buffer #(
  parameter int WORD_BITS = 6
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic clear,
  input wire logic [WORD_BITS-1:0] load_index,
  input wire logic [15:0] load_word,
  input wire logic [WORD_BITS-1:0] rd_index,
  output logic [15:0] rd_word
);

  localparam int DEPTH = 1 << WORD_BITS;

  // whole module state
  typedef struct packed {
    logic [DEPTH-1:0][15:0] words; // buffer storage
    logic [15:0] rd_word;          // registered read data
  } buf_state_t;

  buf_state_t state_reg;
  buf_state_t state_next;

  // next-state: erased words read as all ones, like erased flash
  always_comb begin
    state_next = state_reg;
    state_next.rd_word = state_reg.words[rd_index];
    if (reset || clear) begin
      state_next.words = '1;
    end else if (load) begin
      state_next.words[load_index] = load_word;
    end
    if (reset) begin
      state_next.rd_word = 16'hFFFF;
    end
  end

  // register stage
  always_ff @(posedge ref_clk) begin
    state_reg <= state_next;
  end

  assign rd_word = state_reg.rd_word;

endmodule : page_buffer

`default_nettype wire

// >>> src/self_program_ctrl.sv
// Purpose: boot vector selection and flash self-programming sequencer
// Assumes: APB master on ref_clk; flash macro pulses flash_done when done
// Notes: store instruction is an APB write to the store register
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "self_program_cfg.svh"

module self_program_ctrl #(
  parameter int WORD_BITS = 6,                    // log2 of words per page
  parameter logic [15:0] BOOT_VECTOR = 16'h1000, // loader reset address
  parameter int HALT_START_PAGE = 224             // first halting-section page
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boot_reset_select_fuse,
  input wire logic hardware_boot_enable_fuse,
  input wire logic hardware_boot_pin,
  input wire logic eeprom_write,
  input wire logic flash_done,
  input wire logic [WORD_BITS-1:0] flash_buf_index,
  output logic [15:0] flash_buf_word,
  output logic flash_erase_start,
  output logic flash_write_start,
  output logic [14-WORD_BITS:0] flash_page,
  output logic [14:0] flash_rd_addr,
  input wire logic [15:0] flash_rd_word,
  output logic [15:0] reset_vector,
  output logic boot_entry,
  output logic core_halt,
  output logic readable_section_blocked,
  output logic self_program_irq,
  output logic [3:0] boot_lock_bits
);

  localparam int PAGE_W = 15 - WORD_BITS; // page field width

  // whole module state
  typedef struct packed {
    logic [2:0] pin_sync;        // pin synchroniser chain
    logic pin_level;             // agreed pin level
    logic in_reset;              // reset seen last cycle
    logic boot_entry;            // loader selected at release
    logic [15:0] vector;         // reset vector
    logic [7:0] control;         // self_program_control_status
    logic [2:0] win_cnt;         // cycles left for the store
    logic [15:0] pointer;        // pointer_high_byte:pointer_low_byte
    logic [15:0] data;           // high_data_register:low_data_register
    logic [3:0] lock;            // boot lock bits, 0 = programmed
    self_program_pkg::op_state_t op;
    logic [PAGE_W-1:0] op_page;  // latched page address
    logic erase_start;           // one-cycle start pulses
    logic write_start;
    logic halt;                  // core stalled
    logic irq;                   // completion interrupt
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ctrl_state_t;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;

  // buffer strobes, derived from the bus, flash_done and eeprom_write in the same cycle
  logic buf_load;
  logic buf_clear;

  // command decode on the low six control bits; bit 7 is ignored
  function automatic self_program_pkg::cmd_t decode_cmd(input logic [5:0] bits);
    case (bits)
      `PAT_LOAD: decode_cmd = self_program_pkg::CMD_LOAD;
      `PAT_ERASE: decode_cmd = self_program_pkg::CMD_ERASE;
      `PAT_WRITE: decode_cmd = self_program_pkg::CMD_WRITE;
      `PAT_LOCK: decode_cmd = self_program_pkg::CMD_LOCK;
      `PAT_REEN: decode_cmd = self_program_pkg::CMD_REEN;
      default: decode_cmd = self_program_pkg::CMD_NOP;
    endcase
  endfunction : decode_cmd

  // true when a page lies in the halting section
  function automatic logic in_halting(input logic [PAGE_W-1:0] page);
    in_halting = (32'(page) >= 32'(HALT_START_PAGE));
  endfunction : in_halting

  // drop the command bits and the enable, keep interrupt enable and busy
  // busy must survive loads: only the reenable command may unblock reads
  function automatic logic [7:0] clear_cmd(input logic [7:0] ctrl);
    clear_cmd = ctrl & 8'hC0;
  endfunction : clear_cmd

  // page buffer instance
  page_buffer #(
    .WORD_BITS(WORD_BITS)
  ) page_buffer_i (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(buf_load),
    .clear(buf_clear),
    .load_index(state_reg.pointer[WORD_BITS:1]),
    .load_word(state_reg.data),
    .rd_index(flash_buf_index),
    .rd_word(flash_buf_word)
  );

  // next-state logic
  always_comb begin
    logic setup;
    logic wr_en;
    logic store_hit;
    logic blocked;
    logic [15:0] lpm_byte;
    self_program_pkg::cmd_t cmd;
    setup = 1'b0;
    wr_en = 1'b0;
    store_hit = 1'b0;
    blocked = 1'b0;
    lpm_byte = 16'h0000;
    cmd = self_program_pkg::CMD_NOP;
    state_next = state_reg;
    buf_load = 1'b0;
    buf_clear = 1'b0;

    // pin synchroniser; first stage feeds only the second
    state_next.pin_sync = {state_reg.pin_sync[1:0], hardware_boot_pin};
    if (state_reg.pin_sync[2] == state_reg.pin_sync[1]) begin
      state_next.pin_level = state_reg.pin_sync[2];
    end
    state_next.in_reset = 1'b0;

    // vector chosen once, on the first cycle after release
    if (state_reg.in_reset) begin
      state_next.boot_entry = ~boot_reset_select_fuse
        | (~hardware_boot_enable_fuse & ~state_reg.pin_level);
      state_next.vector = state_next.boot_entry ? BOOT_VECTOR : `RST_APP_VECTOR;
    end

    // start pulses last one cycle
    state_next.erase_start = 1'b0;
    state_next.write_start = 1'b0;

    // apb phases: answer with pready in the access cycle
    setup = psel & ~penable & ~state_reg.pready;
    wr_en = psel & penable & state_reg.pready & pwrite;
    state_next.pready = setup;
    state_next.pslverr = 1'b0;
    state_next.prdata = 32'h0000_0000;

    // program memory load: byte address, bit zero picks the half
    blocked = state_reg.control[`BIT_BUSY]
      & ~in_halting(state_reg.pointer[15:WORD_BITS+1]);
    lpm_byte = state_reg.pointer[0] ? {8'h00, flash_rd_word[15:8]}
      : {8'h00, flash_rd_word[7:0]};

    // read mux, captured in the setup cycle
    if (setup && !pwrite) begin
      case (paddr)
        `OFS_CONTROL: state_next.prdata = {24'h00_0000, state_reg.control};
        `OFS_POINTER: state_next.prdata = {16'h0000, state_reg.pointer};
        `OFS_DATA: state_next.prdata = {16'h0000, state_reg.data};
        `OFS_STORE: state_next.prdata = 32'h0000_0000;
        `OFS_LOCK: state_next.prdata = {28'h000_0000, state_reg.lock};
        `OFS_PM_LOAD: begin
          // a blocked section answers with an error, never stale data
          if (blocked) begin
            state_next.pslverr = 1'b1;
          end else begin
            state_next.prdata = {16'h0000, lpm_byte};
          end
        end
        `OFS_BOOT: state_next.prdata = {15'h0000, state_reg.boot_entry, state_reg.vector};
        default: state_next.pslverr = 1'b1;
      endcase
    end else if (setup) begin
      // fuses and vector are read-only; unmapped writes are flagged
      case (paddr)
        `OFS_CONTROL, `OFS_POINTER, `OFS_DATA, `OFS_STORE, `OFS_LOCK, `OFS_BOOT: begin
          state_next.pslverr = 1'b0;
        end
        `OFS_PM_LOAD: state_next.pslverr = 1'b0;
        default: state_next.pslverr = 1'b1;
      endcase
    end

    // store window countdown; expiry abandons the command
    if (state_reg.win_cnt != 3'h0) begin
      state_next.win_cnt = state_reg.win_cnt - 3'h1;
      if (state_reg.win_cnt == 3'h1 && state_reg.op == self_program_pkg::OP_IDLE) begin
        state_next.control[5:0] = 6'h00;
      end
    end

    // register writes
    if (wr_en) begin
      case (paddr)
        `OFS_CONTROL: begin
          state_next.control[`BIT_IRQEN] = pwdata[`BIT_IRQEN];
          // command bits frozen while a long operation runs
          if (state_reg.op == self_program_pkg::OP_IDLE) begin
            state_next.control[5:0] = pwdata[5:0];
            state_next.win_cnt = pwdata[`BIT_SELF_PROGRAM_ENABLE_BIT] ? `STORE_WINDOW_CYCLES : 3'h0;
          end
        end
        `OFS_POINTER: state_next.pointer = pwdata[15:0];
        `OFS_DATA: state_next.data = pwdata[15:0];
        `OFS_STORE: begin
          store_hit = (state_reg.win_cnt != 3'h0) & state_reg.control[`BIT_SELF_PROGRAM_ENABLE_BIT]
            & (state_reg.op == self_program_pkg::OP_IDLE);
        end
        default: store_hit = 1'b0;
      endcase
    end

    // command execution at the store
    if (store_hit) begin
      cmd = decode_cmd(state_reg.control[5:0]);
      state_next.win_cnt = 3'h0;
      state_next.control = clear_cmd(state_reg.control);
      case (cmd)
        self_program_pkg::CMD_LOAD: begin
          buf_load = 1'b1;
        end
        self_program_pkg::CMD_ERASE, self_program_pkg::CMD_WRITE: begin
          // only the page field is taken; the pointer is then free
          state_next.op_page = state_reg.pointer[15:WORD_BITS+1];
          state_next.op = (cmd == self_program_pkg::CMD_ERASE) ? self_program_pkg::OP_ERASE
            : self_program_pkg::OP_WRITE;
          state_next.erase_start = (cmd == self_program_pkg::CMD_ERASE);
          state_next.write_start = (cmd == self_program_pkg::CMD_WRITE);
          state_next.control = state_reg.control; // enable held until done
          state_next.control[`BIT_BUSY] = 1'b1;
          state_next.halt = in_halting(state_reg.pointer[15:WORD_BITS+1]);
        end
        self_program_pkg::CMD_LOCK: begin
          // zeros program, ones keep; no blocking, no halt
          state_next.lock = state_reg.lock & state_reg.data[`LOCK_MSB:`LOCK_LSB];
        end
        self_program_pkg::CMD_REEN: begin
          state_next.control[`BIT_BUSY] = 1'b0;
          buf_clear = 1'b1;
        end
        default: state_next.control = clear_cmd(state_reg.control);
      endcase
    end

    // completion of erase or write
    if (flash_done && state_reg.op != self_program_pkg::OP_IDLE) begin
      state_next.op = self_program_pkg::OP_IDLE;
      state_next.halt = 1'b0;
      state_next.control[5:0] = 6'h00;
      if (state_reg.op == self_program_pkg::OP_WRITE) begin
        buf_clear = 1'b1;
      end
    end

    // an eeprom write loses everything loaded so far
    if (eeprom_write) begin
      buf_clear = 1'b1;
    end

    // interrupt level follows the enable bit as it will read
    state_next.irq = state_next.control[`BIT_IRQEN] & ~state_next.control[`BIT_SELF_PROGRAM_ENABLE_BIT];

    // synchronous reset; synchroniser keeps shifting so release sees the pin
    if (reset) begin
      state_next.in_reset = 1'b1;
      state_next.boot_entry = 1'b0;
      state_next.vector = `RST_APP_VECTOR;
      state_next.control = 8'h00;
      state_next.win_cnt = 3'h0;
      state_next.pointer = 16'h0000;
      state_next.data = 16'h0000;
      state_next.lock = `RST_LOCK;
      state_next.op = self_program_pkg::OP_IDLE;
      state_next.op_page = '0;
      state_next.erase_start = 1'b0;
      state_next.write_start = 1'b0;
      state_next.halt = 1'b0;
      state_next.irq = 1'b0;
      state_next.prdata = 32'h0000_0000;
      state_next.pready = 1'b0;
      state_next.pslverr = 1'b0;
    end
  end

  // register stage
  always_ff @(posedge ref_clk) begin
    state_reg <= state_next;
  end

  // registered outputs
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign flash_erase_start = state_reg.erase_start;
  assign flash_write_start = state_reg.write_start;
  assign flash_page = state_reg.op_page;
  assign flash_rd_addr = state_reg.pointer[15:1];
  assign reset_vector = state_reg.vector;
  assign boot_entry = state_reg.boot_entry;
  assign core_halt = state_reg.halt;
  assign readable_section_blocked = state_reg.control[`BIT_BUSY];
  assign self_program_irq = state_reg.irq;
  assign boot_lock_bits = state_reg.lock;

endmodule : self_program_ctrl

`default_nettype wire
